// *** include/snp_consts.svh ***
/*
 Constants of the serial program sequencer: command codes, core opcodes,
 special-register addresses, control bit positions and region bases.
 Assumes inclusion by bare name from the design files.
*/
`ifndef SNP_CONSTS_SVH
`define SNP_CONSTS_SVH

// Serial framing
`define SNP_CMD_BITS 5'd4
`define SNP_LAST_BIT 5'd19
`define SNP_DRIVE_FIRST 5'd12

// Four-bit command codes
`define SNP_CMD_CORE 4'h0
`define SNP_CMD_TBLRD_INC 4'h9
`define SNP_CMD_TBLWR_INC2 4'hd
`define SNP_CMD_TBLWR_PROG 4'hf

// Core instruction opcodes
`define SNP_OP_MOVLW 8'h0e
`define SNP_OP_MOVWF 8'h6e
`define SNP_OP_BSF 4'h8
`define SNP_OP_BCF 4'h9

// Special register addresses
`define SNP_SFR_TBL_UPPER 8'hf8
`define SNP_SFR_TBL_HIGH 8'hf7
`define SNP_SFR_TBL_LOW 8'hf6
`define SNP_SFR_ACCESS_CTRL 8'ha6
`define SNP_SFR_EE_DATA 8'ha8
`define SNP_SFR_EE_ADDR_LOW 8'ha9
`define SNP_SFR_EE_ADDR_HIGH 8'haa

// Access control bits and reset value
`define SNP_CTRL_PGM_SEL 7
`define SNP_CTRL_CFG_SEL 6
`define SNP_CTRL_WRITE_ENABLE_BIT 2
`define SNP_CTRL_WR 1
`define SNP_CTRL_RST 8'h00

// Address map and write-start fall count
`define SNP_ID_BASE 22'h200000
`define SNP_ID_LAST 22'h200007
`define SNP_CFG_BASE 22'h300000
`define SNP_CFG_TOP 2'b11
`define SNP_WR_START_FALL 2'd3

`endif

// *** include/snp_pkg.sv ***
/*
 Types of the serial program sequencer.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package snp_pkg;
  typedef enum logic [1:0] {SNP_PROG_IDLE, SNP_PROG_BUF, SNP_PROG_ONE, SNP_PROG_EE} snp_prog_e;
  typedef enum logic [1:0] {SNP_REG_CODE, SNP_REG_ID, SNP_REG_CFG, SNP_REG_EE} snp_region_e;
endpackage : snp_pkg

// *** include/snp_mem_if.sv ***
/*
 Byte port between the sequencer and its nonvolatile array model.
 Assumes one clock shared by both ends.
*/
`timescale 1ns/1ps
`default_nettype none
interface snp_mem_if #(parameter int AW = 10);
  logic we;
  logic [AW-1:0] waddr;
  logic [7:0] wdata;
  logic re;
  logic [AW-1:0] raddr;
  logic [7:0] rdata;
  modport ctl (output we, waddr, wdata, re, raddr, input rdata);
  modport mem (input we, waddr, wdata, re, raddr, output rdata);
endinterface : snp_mem_if
`default_nettype wire

// *** logic/snp_nvm_mem.sv ***
/*
 Byte-wide array with one write and one registered read port.
 Assumes the controller never writes and reads the same cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module snp_nvm_mem #(
  parameter int AW = 10
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // Byte port
  snp_mem_if.mem m
);
  typedef struct packed {
    logic [(1<<AW)-1:0][7:0] mem;
    logic [7:0] rdata;
  } snp_mem_s;

  snp_mem_s q, d;
  logic [7:0] rd_ref;

  assign rd_ref = q.mem[m.raddr];
  assign m.rdata = q.rdata;

  always_comb begin
    d = q;
    if (m.we) begin
      d.mem[m.waddr] = m.wdata;
    end
    if (m.re) begin
      d.rdata = q.mem[m.raddr];
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      q.rdata <= 8'h00;
    end else begin
      q <= d;
    end
  end

  a_read_returns_byte: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    m.re |=> m.rdata == $past(rd_ref)) else $error("read byte mismatch");
endmodule : snp_nvm_mem
`default_nettype wire

// *** logic/snp_prog_seq.sv ***
/*
 Device end of the two-wire serial programming link: command shifter,
 core instruction subset, table pointer, write buffer, data EEPROM write
 timing and a two-entry write buffer ahead of the array.
 Assumes the programmer drives the serial clock well below clk_sys_i / 8.
*/
`timescale 1ns/1ps
`default_nettype none
`include "snp_consts.svh"
module snp_prog_seq #(
  parameter int IDX_W = 8,
  parameter int CODE_BYTES = 65536
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // Serial programming pins
  input wire logic serial_prog_clock_i,
  input wire logic serial_prog_data_i,
  output logic serial_prog_data_o,
  output logic serial_prog_data_oe_n_o,
  // Status
  output logic write_busy_o
);
  localparam int AW = IDX_W + 2;
  localparam logic [21:0] CODE_LAST = 22'(CODE_BYTES - 1);

  typedef struct packed {
    logic pc1, pc2, pc3, pd1, pd2;
    logic [4:0] bcnt;
    logic [3:0] cmd;
    logic [15:0] pay;
    logic [7:0] wreg, ctrl, eeprom_data_latch, eeprom_address_low_l, eeprom_address_low_h;
    logic [21:0] tblptr;
    logic [7:0][7:0] wbuf;
    snp_pkg::snp_prog_e pst;
    logic [2:0] pidx;
    logic [21:0] paddr;
    logic [1:0] fcnt;
    logic [1:0][AW-1:0] fa;
    logic [1:0][7:0] fd;
    logic [1:0] fcount;
    logic fhead;
    logic rd_req, rd_wait;
    logic [AW-1:0] rd_addr;
    logic [7:0] outsh;
    logic dout, doe_n;
  } snp_seq_s;

  localparam snp_seq_s ST_RST = '{doe_n: 1'b1, pst: snp_pkg::SNP_PROG_IDLE,
                                  ctrl: `SNP_CTRL_RST, default: '0};

  snp_seq_s q, d;
  logic rise, fall, pop, ready, exec, ee_start;
  logic push_v;
  logic [AW-1:0] push_a;
  logic [7:0] push_d;
  logic [15:0] np;
  snp_mem_if #(.AW(AW)) mif ();

  function automatic snp_pkg::snp_region_e region_of(input logic [21:0] a,
                                                     input logic cfg_sel);
    if (cfg_sel || a[21:20] == `SNP_CFG_TOP) return snp_pkg::SNP_REG_CFG;
    if (a[21]) return snp_pkg::SNP_REG_ID;
    return snp_pkg::SNP_REG_CODE;
  endfunction : region_of

  function automatic logic [AW-1:0] midx(input snp_pkg::snp_region_e r,
                                         input logic [21:0] a);
    return {2'(r), a[IDX_W-1:0]};
  endfunction : midx

  function automatic logic [7:0] sfr_rd(input snp_seq_s s, input logic [7:0] f);
    unique case (f)
      `SNP_SFR_TBL_UPPER: return {2'b00, s.tblptr[21:16]};
      `SNP_SFR_TBL_HIGH: return s.tblptr[15:8];
      `SNP_SFR_TBL_LOW: return s.tblptr[7:0];
      `SNP_SFR_ACCESS_CTRL: return s.ctrl;
      `SNP_SFR_EE_DATA: return s.eeprom_data_latch;
      `SNP_SFR_EE_ADDR_LOW: return s.eeprom_address_low_l;
      `SNP_SFR_EE_ADDR_HIGH: return s.eeprom_address_low_h;
      default: return 8'h00;
    endcase
  endfunction : sfr_rd

  assign rise = q.pc2 & ~q.pc3;
  assign fall = ~q.pc2 & q.pc3;
  assign ready = q.fcount != 2'd2;
  assign pop = (q.fcount != 2'd0) && !q.rd_req;
  assign np = {q.pd2, q.pay[15:1]};
  assign exec = rise && q.bcnt == `SNP_LAST_BIT;
  assign ee_start = fall && q.ctrl[`SNP_CTRL_WR] && q.pst == snp_pkg::SNP_PROG_IDLE &&
                    q.fcnt == `SNP_WR_START_FALL;

  assign mif.we = pop;
  assign mif.waddr = q.fa[q.fhead];
  assign mif.wdata = q.fd[q.fhead];
  assign mif.re = q.rd_req;
  assign mif.raddr = q.rd_addr;

  always_comb begin
    logic [7:0] wf;
    logic [7:0] wv;
    logic do_sfr;
    logic [2:0] t;
    wf = 8'h00;
    wv = 8'h00;
    do_sfr = 1'b0;
    t = q.tblptr[2:0];
    d = q;
    push_v = 1'b0;
    push_a = '0;
    push_d = 8'h00;
    d.pc1 = serial_prog_clock_i;
    d.pc2 = q.pc1;
    d.pc3 = q.pc2;
    d.pd1 = serial_prog_data_i;
    d.pd2 = q.pd1;
    d.rd_req = 1'b0;
    d.rd_wait = q.rd_req;
    if (q.rd_wait) begin
      d.outsh = mif.rdata;
    end

    // Write start counts falls from the next frame on
    if (!q.ctrl[`SNP_CTRL_WR]) begin
      d.fcnt = 2'd0;
    end else if (fall && q.pst == snp_pkg::SNP_PROG_IDLE && q.bcnt != 5'd0) begin
      d.fcnt = q.fcnt + 2'd1;
    end
    if (ee_start) begin
      if (!q.ctrl[`SNP_CTRL_PGM_SEL] && !q.ctrl[`SNP_CTRL_CFG_SEL]) begin
        d.pst = snp_pkg::SNP_PROG_EE;
      end else begin
        d.ctrl[`SNP_CTRL_WR] = 1'b0;
      end
    end

    // Programming engine feeding the write buffer
    unique case (q.pst)
      snp_pkg::SNP_PROG_IDLE: ;
      snp_pkg::SNP_PROG_BUF: begin
        push_v = 1'b1;
        push_a = midx(region_of(q.paddr, 1'b0), {q.paddr[21:3], q.pidx});
        push_d = q.wbuf[q.pidx];
        if (ready) begin
          d.pidx = q.pidx + 3'd1;
          if (q.pidx == 3'd7) d.pst = snp_pkg::SNP_PROG_IDLE;
        end
      end
      snp_pkg::SNP_PROG_ONE: begin
        push_v = 1'b1;
        push_a = midx(snp_pkg::SNP_REG_CFG, q.paddr);
        push_d = q.wbuf[q.paddr[2:0]];
        if (ready) d.pst = snp_pkg::SNP_PROG_IDLE;
      end
      snp_pkg::SNP_PROG_EE: begin
        push_v = 1'b1;
        push_a = midx(snp_pkg::SNP_REG_EE, {8'h00, q.eeprom_address_low_h[5:0], q.eeprom_address_low_l});
        push_d = q.eeprom_data_latch;
        if (ready) begin
          d.pst = snp_pkg::SNP_PROG_IDLE;
          d.ctrl[`SNP_CTRL_WR] = 1'b0;
        end
      end
    endcase

    // Serial shifter, data captured on rising clock
    if (rise) begin
      if (q.bcnt < `SNP_CMD_BITS) d.cmd = {q.pd2, q.cmd[3:1]};
      else d.pay = np;
      d.bcnt = q.bcnt + 5'd1;
      if (q.bcnt == `SNP_CMD_BITS - 5'd1 && {q.pd2, q.cmd[3:1]} == `SNP_CMD_TBLRD_INC) begin
        d.rd_req = 1'b1;
        d.rd_addr = midx(region_of(q.tblptr, q.ctrl[`SNP_CTRL_CFG_SEL]), q.tblptr);
        d.tblptr = (q.tblptr == CODE_LAST) ? 22'h000000 : q.tblptr + 22'd1;
      end
      if (q.cmd == `SNP_CMD_TBLRD_INC && q.bcnt >= `SNP_DRIVE_FIRST) begin
        d.dout = q.outsh[0];
        d.outsh = {1'b0, q.outsh[7:1]};
        d.doe_n = 1'b0;
      end
      if (exec) d.bcnt = 5'd0;
    end
    if (fall && q.bcnt == 5'd0) d.doe_n = 1'b1;

    if (exec) begin
      unique case (q.cmd)
        `SNP_CMD_CORE: begin
          if (np[15:8] == `SNP_OP_MOVLW) begin
            d.wreg = np[7:0];
          end else if (np[15:8] == `SNP_OP_MOVWF) begin
            wf = np[7:0];
            wv = q.wreg;
            do_sfr = 1'b1;
          end else if (np[15:12] == `SNP_OP_BSF || np[15:12] == `SNP_OP_BCF) begin
            wf = np[7:0];
            wv = (np[15:12] == `SNP_OP_BSF) ? (sfr_rd(q, wf) | (8'h01 << np[11:9]))
                                            : (sfr_rd(q, wf) & ~(8'h01 << np[11:9]));
            do_sfr = 1'b1;
          end
        end
        `SNP_CMD_TBLWR_INC2: begin
          d.wbuf[t] = np[7:0];
          d.wbuf[t + 3'd1] = np[15:8];
          d.tblptr = q.tblptr + 22'd2;
        end
        `SNP_CMD_TBLWR_PROG: begin
          d.paddr = q.tblptr;
          if (q.ctrl[`SNP_CTRL_CFG_SEL]) begin
            d.wbuf[t] = q.tblptr[0] ? np[15:8] : np[7:0];
            d.pst = snp_pkg::SNP_PROG_ONE;
          end else begin
            d.wbuf[t] = np[7:0];
            d.wbuf[t + 3'd1] = np[15:8];
            d.pidx = 3'd0;
            d.pst = snp_pkg::SNP_PROG_BUF;
          end
        end
        default: ;
      endcase
    end

    if (do_sfr) begin
      unique case (wf)
        `SNP_SFR_TBL_UPPER: d.tblptr[21:16] = wv[5:0];
        `SNP_SFR_TBL_HIGH: d.tblptr[15:8] = wv;
        `SNP_SFR_TBL_LOW: d.tblptr[7:0] = wv;
        `SNP_SFR_EE_DATA: d.eeprom_data_latch = wv;
        `SNP_SFR_EE_ADDR_LOW: d.eeprom_address_low_l = wv;
        `SNP_SFR_EE_ADDR_HIGH: d.eeprom_address_low_h = wv;
        `SNP_SFR_ACCESS_CTRL: begin
          // Write-start needs write enable; software cannot clear it
          wv[`SNP_CTRL_WR] = d.ctrl[`SNP_CTRL_WR] |
                             (wv[`SNP_CTRL_WR] & q.ctrl[`SNP_CTRL_WRITE_ENABLE_BIT]);
          d.ctrl = wv;
        end
        default: ;
      endcase
    end

    // Two-entry write buffer
    if (push_v && ready) begin
      d.fa[q.fhead ^ q.fcount[0]] = push_a;
      d.fd[q.fhead ^ q.fcount[0]] = push_d;
    end
    if (pop) d.fhead = ~q.fhead;
    d.fcount = q.fcount + {1'b0, push_v && ready} - {1'b0, pop};
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      q <= ST_RST;
    end else begin
      q <= d;
    end
  end

  assign serial_prog_data_o = q.dout;
  assign serial_prog_data_oe_n_o = q.doe_n;
  assign write_busy_o = q.ctrl[`SNP_CTRL_WR];

  snp_nvm_mem #(.AW(AW)) u_mem (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .m(mif)
  );

  a_wr_needs_write_enable_bit: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    $rose(q.ctrl[`SNP_CTRL_WR]) |-> $past(q.ctrl[`SNP_CTRL_WRITE_ENABLE_BIT]))
    else $error("write started without enable");
  a_wr_fourth_fall: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (q.pst == snp_pkg::SNP_PROG_IDLE && d.pst == snp_pkg::SNP_PROG_EE) |->
      fall && q.fcnt == 2'd3) else $error("write start not on fourth fall");
  a_wr_hw_clear: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    q.pst == snp_pkg::SNP_PROG_EE |-> ##[0:8] !q.ctrl[`SNP_CTRL_WR])
    else $error("write bit not cleared");
  a_ee_byte_data: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (q.pst == snp_pkg::SNP_PROG_EE && ready) |=>
      mif.we && mif.wdata == $past(q.eeprom_data_latch)) else $error("eeprom byte lost");
  a_ptr_plus_two: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (exec && q.cmd == `SNP_CMD_TBLWR_INC2) |=> q.tblptr == $past(q.tblptr) + 22'd2)
    else $error("pointer not advanced by two");
  a_ptr_wrap: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (d.rd_req && q.tblptr == CODE_LAST) |=> q.tblptr == 22'h000000)
    else $error("pointer did not wrap");
  a_cfg_byte_sel: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (exec && q.cmd == `SNP_CMD_TBLWR_PROG && q.ctrl[`SNP_CTRL_CFG_SEL]) |=>
      q.wbuf[q.paddr[2:0]] == ($past(q.tblptr[0]) ? $past(np[15:8]) : $past(np[7:0])))
    else $error("wrong config byte chosen");
  a_buf_burst: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (exec && q.cmd == `SNP_CMD_TBLWR_PROG && !q.ctrl[`SNP_CTRL_CFG_SEL]) |=>
      q.pst == snp_pkg::SNP_PROG_BUF ##[8:40] q.pst == snp_pkg::SNP_PROG_IDLE)
    else $error("buffer programming burst wrong");
  a_frame_len: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (rise && q.bcnt == `SNP_LAST_BIT) |=> q.bcnt == 5'd0) else $error("frame length");
endmodule : snp_prog_seq
`default_nettype wire

// *** tb/snp_prog_model.sv ***
/*
 Programmer model: drives the serial clock and data pins frame by frame.
 Assumes the bench resolves nothing else on the data wire.
*/
`timescale 1ns/1ps
`default_nettype none
module snp_prog_model #(
  parameter int HOLD_HI = 20,
  parameter int HOLD_LO = 20
) (
  // Clock
  input wire logic clk_sys_i,
  // Device side of the data pin
  input wire logic dev_data_i,
  input wire logic dev_oe_n_i,
  // Pins towards the device
  output logic pgm_clk_o,
  output logic pgm_data_o
);
  logic drv_q = 1'b0;
  logic rel_q = 1'b0;
  logic tog_q = 1'b0;
  int n_fall = 0;
  initial pgm_clk_o = 1'b0;
  // Released line shows a changing pattern
  always @(negedge clk_sys_i) tog_q <= ~tog_q;
  assign pgm_data_o = !dev_oe_n_i ? dev_data_i : (rel_q ? tog_q : drv_q);

  task automatic frame(input logic [3:0] cmd, input logic [15:0] pl, input bit rd,
      input int hi3, output logic [7:0] rbyte);
    logic [19:0] bits;
    bits = {pl, cmd};
    rbyte = 8'h00;
    for (int i = 0; i < 20; i++) begin
      @(negedge clk_sys_i);
      drv_q = bits[i];
      rel_q = rd && (i >= 12);
      repeat (4) @(negedge clk_sys_i);
      pgm_clk_o = 1'b1;
      repeat ((i == 3) ? hi3 : 4) @(negedge clk_sys_i);
      if (rel_q) rbyte[i-12] = pgm_data_o;
      pgm_clk_o = 1'b0;
      n_fall++;
    end
    repeat (4) @(negedge clk_sys_i);
    rel_q = 1'b0;
  endtask : frame

  task automatic nop();
    logic [7:0] r;
    frame(4'h0, 16'h0000, 1'b0, HOLD_HI, r);
    repeat (HOLD_LO) @(negedge clk_sys_i);
  endtask : nop
endmodule : snp_prog_model
`default_nettype wire

// *** tb/test_snp_prog_seq.sv ***
/*
 Self-checking bench: ID, code, configuration and data EEPROM sequences.
 Assumes the sequencer holds its own array; code size shrunk to 256 bytes.
*/
`timescale 1ns/1ps
`default_nettype none
module test_snp_prog_seq;
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic sclk;
  logic sdat;
  logic dout;
  logic oe_n;
  logic busy;
  logic [7:0] b;
  int fails = 0;
  int n_tests = 0;
  int cyc = 0;
  int nf;

  always #5 clk_sys_i = ~clk_sys_i;

  snp_prog_seq #(.IDX_W(8), .CODE_BYTES(256)) dut_u (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .serial_prog_clock_i(sclk),
    .serial_prog_data_i(sdat),
    .serial_prog_data_o(dout),
    .serial_prog_data_oe_n_o(oe_n),
    .write_busy_o(busy)
  );

  snp_prog_model pm_u (
    .clk_sys_i(clk_sys_i),
    .dev_data_i(dout),
    .dev_oe_n_i(oe_n),
    .pgm_clk_o(sclk),
    .pgm_data_o(sdat)
  );

  task automatic stop_test();
    $display("tests %0d fails %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : stop_test

  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 60000) begin
      fails++;
      stop_test();
    end
  end

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk8

  task automatic chk1(input logic got, input logic exp);
    chk8({7'h00, got}, {7'h00, exp});
  endtask : chk1

  task automatic core(input logic [15:0] pl);
    logic [7:0] r;
    pm_u.frame(4'h0, pl, 1'b0, 4, r);
  endtask : core

  task automatic set_ptr(input logic [21:0] a);
    core({8'h0e, 2'b00, a[21:16]});
    core(16'h6ef8);
    core({8'h0e, a[15:8]});
    core(16'h6ef7);
    core({8'h0e, a[7:0]});
    core(16'h6ef6);
  endtask : set_ptr

  task automatic rd(output logic [7:0] v);
    pm_u.frame(4'h9, 16'h0000, 1'b1, 4, v);
    chk1(oe_n, 1'b1);
  endtask : rd

  // Eight bytes base+0..base+7 into the block at a
  task automatic wr_block(input logic [21:0] a, input logic [7:0] base);
    logic [7:0] lo;
    logic [7:0] r;
    set_ptr(a);
    for (int k = 0; k < 4; k++) begin
      lo = base + 8'(2 * k);
      pm_u.frame((k == 3) ? 4'hf : 4'hd, {lo + 8'h01, lo}, 1'b0, 4, r);
    end
    pm_u.nop();
  endtask : wr_block

  task automatic chk_block(input logic [21:0] a, input logic [7:0] base);
    logic [7:0] v;
    set_ptr(a);
    for (int k = 0; k < 8; k++) begin
      rd(v);
      chk8(v, base + 8'(k));
    end
  endtask : chk_block

  initial begin
    repeat (2) @(negedge clk_sys_i);
    rst_n_i = 1'b1;
    repeat (3) @(negedge clk_sys_i);
    chk1(oe_n, 1'b1);
    chk1(busy, 1'b0);
    // ID locations
    core(16'h8ea6);
    core(16'h9ca6);
    wr_block(22'h200000, 8'h40);
    chk_block(22'h200000, 8'h40);
    // Code, boot block and pointer wrap
    wr_block(22'h0000f8, 8'h80);
    wr_block(22'h000000, 8'h10);
    chk_block(22'h0000f8, 8'h80);
    rd(b);
    chk8(b, 8'h10);
    // ID rewritten, read back, pointer reloaded after code verify
    wr_block(22'h200000, 8'h48);
    chk_block(22'h200000, 8'h48);
    // Configuration bytes, odd first
    core(16'h8ca6);
    set_ptr(22'h300001);
    pm_u.frame(4'hf, 16'h3cc3, 1'b0, 4, b);
    pm_u.nop();
    set_ptr(22'h300000);
    pm_u.frame(4'hf, 16'h5aa5, 1'b0, 4, b);
    pm_u.nop();
    set_ptr(22'h300000);
    rd(b);
    chk8(b, 8'ha5);
    rd(b);
    chk8(b, 8'h3c);
    // Data EEPROM byte write
    core(16'h9ca6);
    core(16'h9ea6);
    core(16'h0e33);
    core(16'h6ea9);
    core(16'h0e00);
    core(16'h6eaa);
    core(16'h0e5c);
    core(16'h6ea8);
    core(16'h94a6);
    core(16'h82a6);
    repeat (4) @(negedge clk_sys_i);
    chk1(busy, 1'b0);
    core(16'h84a6);
    core(16'h82a6);
    repeat (4) @(negedge clk_sys_i);
    chk1(busy, 1'b1);
    nf = pm_u.n_fall;
    fork
      pm_u.nop();
      begin
        wait (pm_u.n_fall == nf + 3);
        repeat (4) @(negedge clk_sys_i);
        chk1(busy, 1'b1);
        wait (pm_u.n_fall == nf + 4);
        repeat (4) @(negedge clk_sys_i);
        chk1(busy, 1'b0);
      end
    join
    stop_test();
  end
endmodule : test_snp_prog_seq
`default_nettype wire
